// *** logic/tja_adapter.v ***
/*
 * Tributary justification adapter: sink demaps one 34 Mbit/s
 * tributary timeslot from the aggregate frame, source maps one in.
 * Assumes link clocks far slower than pclk; APB register access.
 */
// Our own choices: the address map and the APB slave port.
//
// Behaviour
// R1 - J bit is data when C majority zero
// R2 - majority vote over five control bits
// R3 - sink store written by gapped aggregate clock
// R4 - sink store read by smoothed even clock
// R5 - sink store sized against offset and jitter
// R6 - sink recovers after frequency step, bounded time
// R7 - one selected timeslot of four per instance
// R8 - inactive sink sends ones, reports nothing (tributary_server_fail still follows trail fail while inactive)
// R9 - trail fail raises alarm and signal fail
// R10 - alarm clear restores data within limit
// R11 - source places tributary into selected timeslot
// R12 - source store written by tributary clock
// R13 - source store read under aggregate timing
// R14 - justification skips one read, J empty
// R15 - source writes five control bits per frame
// R16 - source store tolerant of offset, jitter
// R17 - source drives timeslot only when active
// R18 - only one source active per access point
`timescale 1ns/1ns
`include "tja_defs.vh"

module tja_adapter #(
    parameter AIS_CYCLES = `TJA_AIS_TIME_US * `TJA_PCLK_MHZ
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire aggregate_adapted_data,
    input wire aggregate_adapted_clock,
    input wire aggregate_frame_start,
    input wire aggregate_trail_fail,
    output reg tributary_out_data,
    output reg tributary_out_clock,
    output reg tributary_server_fail,
    input wire tributary_in_data,
    input wire tributary_in_clock,
    input wire aggregate_timing_clock,
    input wire aggregate_timing_frame_start,
    output reg src_aggregate_data,
    output reg src_aggregate_clock,
    output reg src_aggregate_frame_start,
    output reg src_aggregate_drive_n
);

localparam S_FAIL = 2'h0;
localparam S_PRIME = 2'h1;
localparam S_RUN = 2'h2;

// ---------------------------------------------------------------
// functions
// ---------------------------------------------------------------
function [11:0] tja_next_pos;
    input [11:0] pos;
    input fs;
    begin
        if (fs || pos == `TJA_FRAME_LAST)
            tja_next_pos = 12'h000;
        else
            tja_next_pos = pos + 12'h001;
    end
endfunction

function [1:0] tja_kind;
    input [11:0] pos;
    input [1:0] slot;
    integer k;
    reg [31:0] t;
    reg [11:0] off;
    reg [2:0] set;
    begin
        set = 3'h0;
        off = pos;
        for (k = 1; k <= `TJA_SET_LAST; k = k + 1) begin
            t = pos - k * `TJA_SET_BITS;
            if (pos >= k * `TJA_SET_BITS) begin
                set = k[2:0];
                off = t[11:0];
            end
        end
        if (off[1:0] != slot)
            tja_kind = `TJA_KIND_NONE;
        else if (set == 3'h0 && off < `TJA_OVH_END)
            tja_kind = `TJA_KIND_NONE;
        else if (set != 3'h0 && off < `TJA_CBIT_END)
            tja_kind = `TJA_KIND_CTRL;
        else if (set == `TJA_SET_LAST && off < `TJA_JBIT_END)
            tja_kind = `TJA_KIND_JOPP;
        else
            tja_kind = `TJA_KIND_DATA;
    end
endfunction

// ---------------------------------------------------------------
// input synchronisers and link clock edges
// ---------------------------------------------------------------
reg [7:0] sync1;
reg [7:0] sync2;
reg [2:0] clk_prev;
wire [7:0] pins_in = {aggregate_timing_frame_start, aggregate_timing_clock,
                      tributary_in_data, tributary_in_clock,
                      aggregate_trail_fail, aggregate_frame_start,
                      aggregate_adapted_data, aggregate_adapted_clock};

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sync1 <= 8'h00;
        sync2 <= 8'h00;
        clk_prev <= 3'h0;
    end else if (clk_en) begin
        sync1 <= pins_in;
        sync2 <= sync1;
        clk_prev <= {sync2[6], sync2[4], sync2[0]};
    end
end

wire agg_rise = sync2[0] & ~clk_prev[0];
wire trib_rise = sync2[4] & ~clk_prev[1];
wire tim_rise = sync2[6] & ~clk_prev[2];
wire agg_data = sync2[1];
wire agg_fs = sync2[2];
wire agg_tsf = sync2[3];

// ---------------------------------------------------------------
// control register
// ---------------------------------------------------------------
reg snk_act;
reg src_act;
reg [1:0] slot;

// ---------------------------------------------------------------
// sink: justification control interpretation
// ---------------------------------------------------------------
reg [11:0] snk_pos;
reg [2:0] snk_votes;
reg snk_just;
reg [1:0] snk_state;
reg [31:0] prime_cnt;
reg [15:0] nco_acc;
wire [11:0] snk_cur = tja_next_pos(snk_pos, agg_fs);
wire [1:0] snk_kind = tja_kind(snk_cur, slot); // [R7]
wire snk_j_data = (snk_votes < `TJA_VOTE_MAJ); // [R1] [R2]
wire snk_rdata;
wire [`TJA_FIFO_AW:0] snk_fill;
wire snk_empty;
wire snk_full;
wire snk_fail_in = agg_tsf | ~snk_act;

// gapped write: no pulse at overhead, C or stuffed J
wire snk_wr = agg_rise && snk_state != S_FAIL &&
              (snk_kind == `TJA_KIND_DATA ||
               (snk_kind == `TJA_KIND_JOPP && snk_j_data)); // [R3] [R1]

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        snk_pos <= 12'h000;
        snk_votes <= 3'h0;
        snk_just <= 1'b0;
    end else if (clk_en && agg_rise) begin
        snk_pos <= snk_cur;
        if (snk_cur == 12'h000)
            snk_votes <= 3'h0;
        else if (snk_kind == `TJA_KIND_CTRL)
            snk_votes <= snk_votes + {2'h0, agg_data}; // [R2]
        if (snk_kind == `TJA_KIND_JOPP)
            snk_just <= ~snk_j_data;
    end
end

// ---------------------------------------------------------------
// sink: smoothed read clock
// ---------------------------------------------------------------
wire [16:0] nco_step = {1'b0, `TJA_NCO_STEP} + {10'h000, snk_fill} -
                       {10'h000, `TJA_FIFO_HALF};
wire [16:0] nco_sum = {1'b0, nco_acc} + {1'b0, nco_step[15:0]};
wire nco_carry = nco_sum[16];
wire snk_rd = nco_carry && snk_state == S_RUN; // [R4]
wire snk_slip = (snk_rd && snk_empty) || (snk_wr && snk_full);
wire snk_flush = (snk_state == S_FAIL) ||
                 (snk_state == S_RUN && snk_slip); // [R5] [R6]

tja_elastic u_snk_store (
    .clk(pclk),
    .rst_n(presetn),
    .ce(clk_en),
    .flush(snk_flush),
    .wr(snk_wr),
    .wdata(agg_data),
    .rd(snk_rd),
    .rdata(snk_rdata),
    .fill(snk_fill),
    .empty(snk_empty),
    .full(snk_full)
);

// ---------------------------------------------------------------
// sink: alarm state and output
// ---------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        snk_state <= S_FAIL;
        prime_cnt <= 32'h0000_0000;
    end else if (clk_en) begin
        case (snk_state)
            S_FAIL: begin
                prime_cnt <= 32'h0000_0000;
                if (!snk_fail_in)
                    snk_state <= S_PRIME;
            end
            S_PRIME: begin
                prime_cnt <= prime_cnt + 32'h0000_0001;
                if (snk_fail_in)
                    snk_state <= S_FAIL; // [R9]
                else if (snk_fill >= `TJA_FIFO_HALF ||
                         prime_cnt >= AIS_CYCLES - 1)
                    snk_state <= S_RUN; // [R10]
            end
            S_RUN: begin
                prime_cnt <= 32'h0000_0000;
                if (snk_fail_in)
                    snk_state <= S_FAIL; // [R9]
                else if (snk_slip)
                    snk_state <= S_PRIME; // [R6]
            end
            default: begin
                snk_state <= S_FAIL;
            end
        endcase
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        nco_acc <= 16'h0000;
        tributary_out_clock <= 1'b0;
        tributary_out_data <= 1'b1;
        tributary_server_fail <= 1'b0;
    end else if (clk_en) begin
        nco_acc <= nco_sum[15:0];
        tributary_out_clock <= nco_sum[15]; // [R4]
        tributary_server_fail <= agg_tsf; // [R9]
        if (snk_fail_in || snk_state != S_RUN)
            tributary_out_data <= 1'b1; // [R8] [R9]
        else if (snk_rd)
            tributary_out_data <= snk_rdata;
    end
end

// ---------------------------------------------------------------
// source: store and justification
// ---------------------------------------------------------------
reg [11:0] src_pos;
reg src_just;
wire [11:0] src_cur = tja_next_pos(src_pos, sync2[7]);
wire [1:0] src_kind = tja_kind(src_cur, slot); // [R7] [R11]
wire src_rdata;
wire [`TJA_FIFO_AW:0] src_fill;
wire src_wr = trib_rise && src_act; // [R12]
wire src_rd = tim_rise && src_act &&
              (src_kind == `TJA_KIND_DATA ||
               (src_kind == `TJA_KIND_JOPP && !src_just)); // [R13] [R14]

tja_elastic u_src_store (
    .clk(pclk),
    .rst_n(presetn),
    .ce(clk_en),
    .flush(~src_act),
    .wr(src_wr),
    .wdata(sync2[5]),
    .rd(src_rd),
    .rdata(src_rdata),
    .fill(src_fill),
    .empty(),
    .full()
);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        src_pos <= 12'h000;
        src_just <= 1'b0;
        src_aggregate_data <= 1'b1;
        src_aggregate_clock <= 1'b1;
        src_aggregate_frame_start <= 1'b0;
        src_aggregate_drive_n <= 1'b1;
    end else if (clk_en) begin
        src_aggregate_clock <= ~sync2[6];
        if (tim_rise) begin
            src_aggregate_frame_start <= sync2[7] & src_act;
            src_pos <= src_cur;
            // low store: stuff this frame
            if (src_cur == 12'h000)
                src_just <= (src_fill < `TJA_FIFO_HALF); // [R14] [R16]
            case (src_kind)
                `TJA_KIND_DATA: begin
                    src_aggregate_data <= src_rdata; // [R11]
                    src_aggregate_drive_n <= ~src_act; // [R17]
                end
                `TJA_KIND_CTRL: begin
                    src_aggregate_data <= src_just; // [R15]
                    src_aggregate_drive_n <= ~src_act; // [R17]
                end
                `TJA_KIND_JOPP: begin
                    src_aggregate_data <= src_just ? 1'b0 : src_rdata; // [R14]
                    src_aggregate_drive_n <= ~src_act; // [R17]
                end
                default: begin
                    src_aggregate_drive_n <= 1'b1;
                end
            endcase
        end
    end
end

// ---------------------------------------------------------------
// APB slave
// ---------------------------------------------------------------
wire apb_setup = psel && !penable;
wire apb_write = psel && penable && pready && pwrite;
wire apb_hit = (paddr == `TJA_REG_CTRL) || (paddr == `TJA_REG_STATUS);
reg [31:0] next_prdata;

always @* begin
    next_prdata = 32'h0000_0000;
    if (paddr == `TJA_REG_CTRL) begin
        next_prdata[`TJA_CTRL_SNK_ACT] = snk_act;
        next_prdata[`TJA_CTRL_SRC_ACT] = src_act;
        next_prdata[`TJA_CTRL_SLOT_LSB+1:`TJA_CTRL_SLOT_LSB] = slot;
    end else if (paddr == `TJA_REG_STATUS) begin
        // sink status hidden while the sink is inactive
        if (snk_act) begin
            next_prdata[`TJA_ST_ALARM] = (snk_state != S_RUN); // [R8]
            next_prdata[`TJA_ST_SSF] = agg_tsf;
            next_prdata[`TJA_ST_JUST] = snk_just;
            next_prdata[`TJA_ST_SNK_FILL+`TJA_FIFO_AW:`TJA_ST_SNK_FILL] =
                snk_fill;
        end
        next_prdata[`TJA_ST_SRC_FILL+`TJA_FIFO_AW:`TJA_ST_SRC_FILL] =
            src_fill;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
        {slot, src_act, snk_act} <= `TJA_CTRL_RESET;
    end else if (clk_en) begin
        pready <= apb_setup;
        pslverr <= apb_setup && !apb_hit;
        if (apb_setup)
            prdata <= next_prdata;
        if (apb_write && paddr == `TJA_REG_CTRL) begin
            snk_act <= pwdata[`TJA_CTRL_SNK_ACT];
            src_act <= pwdata[`TJA_CTRL_SRC_ACT]; // [R18]
            slot <= pwdata[`TJA_CTRL_SLOT_LSB+1:`TJA_CTRL_SLOT_LSB];
        end
    end
end

endmodule // tja_adapter

// *** logic/tja_defs.vh ***
/*
 * Constants of the tributary justification adapter: frame geometry,
 * elastic store sizing, register map and timing figures.
 * Assumes inclusion by bare name from the adapter design files.
 */
`ifndef TJA_DEFS_VH
`define TJA_DEFS_VH

// ---------------------------------------------------------------
// aggregate frame geometry (bit interleaved, four timeslots)
// ---------------------------------------------------------------
`define TJA_FRAME_LAST 12'h0B6F
`define TJA_SET_BITS 12'h01E8
`define TJA_SET_LAST 3'h5
`define TJA_OVH_END 12'h0010
`define TJA_CBIT_END 12'h0004
`define TJA_JBIT_END 12'h0008
`define TJA_VOTE_MAJ 3'h3

// ---------------------------------------------------------------
// bit kinds within the own timeslot
// ---------------------------------------------------------------
`define TJA_KIND_NONE 2'h0
`define TJA_KIND_DATA 2'h1
`define TJA_KIND_CTRL 2'h2
`define TJA_KIND_JOPP 2'h3

// ---------------------------------------------------------------
// elastic store and read clock
// ---------------------------------------------------------------
`define TJA_FIFO_AW 6
`define TJA_FIFO_DEPTH 64
`define TJA_FIFO_HALF 7'h20
`define TJA_NCO_STEP 16'h07E7

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define TJA_REG_CTRL 8'h00
`define TJA_REG_STATUS 8'h04
`define TJA_CTRL_SNK_ACT 0
`define TJA_CTRL_SRC_ACT 1
`define TJA_CTRL_SLOT_LSB 2
`define TJA_CTRL_RESET 4'h0
`define TJA_ST_ALARM 0
`define TJA_ST_SSF 1
`define TJA_ST_JUST 2
`define TJA_ST_SNK_FILL 8
`define TJA_ST_SRC_FILL 16

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define TJA_PCLK_MHZ 10
`define TJA_AIS_TIME_US 900

`endif

// *** logic/tja_elastic.v ***
/*
 * One-bit wide elastic store used by sink and source paths.
 * Assumes write and read strobes are single pclk pulses.
 */
`timescale 1ns/1ns
`include "tja_defs.vh"

module tja_elastic (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire flush,
    input wire wr,
    input wire wdata,
    input wire rd,
    output wire rdata,
    output wire [`TJA_FIFO_AW:0] fill,
    output wire empty,
    output wire full
);

reg [`TJA_FIFO_DEPTH-1:0] mem;
reg [`TJA_FIFO_AW:0] wptr;
reg [`TJA_FIFO_AW:0] rptr;

assign fill = wptr - rptr;
assign empty = (wptr == rptr);
assign full = (fill == `TJA_FIFO_DEPTH);
assign rdata = mem[rptr[`TJA_FIFO_AW-1:0]];

// ---------------------------------------------------------------
// pointers and storage
// ---------------------------------------------------------------
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        mem <= {`TJA_FIFO_DEPTH{1'b0}};
        wptr <= {(`TJA_FIFO_AW+1){1'b0}};
        rptr <= {(`TJA_FIFO_AW+1){1'b0}};
    end else if (ce) begin
        if (flush) begin
            // drop contents, restart from empty
            rptr <= wptr;
        end else begin
            if (wr && !full) begin
                mem[wptr[`TJA_FIFO_AW-1:0]] <= wdata;
                wptr <= wptr + 1'b1;
            end
            if (rd && !empty) begin
                rptr <= rptr + 1'b1;
            end
        end
    end
end

endmodule // tja_elastic

// *** test/tja_far_end.sv ***
/*
 * Far-end model: aggregate frames with timing, and a tributary feed.
 * Assumes the bench sets the timeslot field and the control pattern.
 */
`timescale 1ns/1ns
`include "tja_defs.vh"

module tja_far_end (
    input wire logic [1:0] slot,
    input wire logic [4:0] cpat,
    output logic link_clock,
    output logic link_data,
    output logic link_fs,
    output logic trib_clock,
    output logic trib_data,
    output logic [7:0] frame_no
);
    integer seed = 47;
    logic [11:0] pos;
    logic [11:0] set;
    logic [11:0] off;

    // ---------------------------------------------------------------
    // aggregate frame, one bit per 800 ns, free running
    // ---------------------------------------------------------------
    initial begin
        link_clock = 1'b0;
        pos = 12'h0000;
        frame_no = 8'h00;
        #37;
        forever begin
            set = pos / `TJA_SET_BITS;
            off = pos % `TJA_SET_BITS;
            link_fs = (pos == 12'h0000);
            link_data = 1'($random(seed));
            if (set != 0 && off < `TJA_CBIT_END && off[1:0] == slot) begin
                link_data = cpat[set - 12'h0001];
            end
            #400 link_clock = 1'b1;
            #400 link_clock = 1'b0;
            if (pos == `TJA_FRAME_LAST) begin
                pos = 12'h0000;
                frame_no = frame_no + 8'h01;
            end else begin
                pos = pos + 12'h0001;
            end
        end
    end

    // slightly slow feed, so the source keeps justifying
    initial begin
        trib_clock = 1'b0;
        trib_data = 1'b0;
        #211;
        forever begin
            #1650 trib_clock = 1'b1;
            #1650 trib_clock = 1'b0;
            trib_data = 1'($random(seed));
        end
    end
endmodule // tja_far_end

// *** test/tja_adapter_chk_sva.sv ***
/*
 * Port checker of the adapter: APB answer, idle outputs, fail path.
 * Assumes it is bound to tja_adapter with clk_en held high.
 */
`timescale 1ns/1ns

module tja_adapter_chk #(
    parameter AIS_CYCLES = 9000
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire aggregate_trail_fail,
    input wire tributary_out_data,
    input wire tributary_server_fail,
    input wire src_aggregate_frame_start,
    input wire src_aggregate_drive_n
);
    reg snk_act;
    reg src_act;
    reg [7:0] snk_off;
    reg [7:0] src_off;
    reg [15:0] fail_cnt;

    // ---------------------------------------------------------------
    // shadow of activation bits, idle and fail counters
    // ---------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snk_act <= 1'b0;
            src_act <= 1'b0;
            snk_off <= 8'h00;
            src_off <= 8'h00;
            fail_cnt <= 16'h0000;
        end else begin
            if (psel && penable && pready && pwrite && paddr == 8'h00) begin
                snk_act <= pwdata[0];
                src_act <= pwdata[1];
            end
            snk_off <= snk_act ? 8'h00 : snk_off + {7'h00, snk_off != 8'hFF};
            src_off <= src_act ? 8'h00 : src_off + {7'h00, src_off != 8'hFF};
            fail_cnt <= !tributary_server_fail ? 16'h0000 :
                fail_cnt + {15'h0000, fail_cnt != 16'hFFFF};
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_setup_answer: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_unmapped_err: assert property (psel && !penable && paddr != 8'h00
        && paddr != 8'h04 |=> pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (psel && !penable
        && (paddr == 8'h00 || paddr == 8'h04) |=> !pslverr)
        else $error("mapped access refused");
    a_sink_idle: assert property (snk_off > 8'h40 |-> tributary_out_data)
        else $error("inactive sink not sending ones");
    a_status_quiet: assert property (pready && !pwrite && paddr == 8'h04
        && !snk_act |-> prdata[14:0] == 15'h0000)
        else $error("inactive sink reports status");
    a_src_idle: assert property (src_off > 8'h10
        |-> src_aggregate_drive_n && !src_aggregate_frame_start)
        else $error("inactive source drives aggregate");
    a_fail_flag: assert property ($rose(aggregate_trail_fail)
        |-> ##[1:5] tributary_server_fail)
        else $error("signal fail not raised");
    a_fail_drop: assert property ($fell(aggregate_trail_fail)
        |-> ##[1:5] !tributary_server_fail)
        else $error("signal fail not cleared");
    // one output bit of slack after the alarm time
    a_ais_ones: assert property (fail_cnt > AIS_CYCLES + 40
        |-> tributary_out_data)
        else $error("no all ones after trail fail");

    c_fail: cover property ($rose(tributary_server_fail));
    c_drive: cover property ($fell(src_aggregate_drive_n));
    c_refuse: cover property (pready && pslverr);
endmodule // tja_adapter_chk

bind tja_adapter tja_adapter_chk #(.AIS_CYCLES(AIS_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .aggregate_trail_fail(aggregate_trail_fail),
    .tributary_out_data(tributary_out_data),
    .tributary_server_fail(tributary_server_fail),
    .src_aggregate_frame_start(src_aggregate_frame_start),
    .src_aggregate_drive_n(src_aggregate_drive_n)
);

// *** test/testbench.sv ***
/*
 * Self-checking bench of the adapter: registers, source frame layout,
 * justification voting, trail fail and deactivation.
 * Assumes tja_far_end supplies aggregate frames and tributary feed.
 */
`timescale 1ns/1ns
`include "tja_defs.vh"

module testbench;
    localparam AIS = 200;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic trail_fail = 1'b0;
    logic [1:0] slot = 2'h0;
    logic [4:0] cpat = 5'h00;
    logic [4:0] pats [0:1] = '{5'b00100, 5'b11011};
    wire [31:0] prdata;
    wire pready, pslverr, a_clk, a_data, a_fs, t_clk, t_data;
    wire out_data, ssf, s_data, s_clk, s_fs, s_drive_n;
    wire [7:0] frame_no;
    integer seed = 47;
    integer err_count = 0;
    integer cmp_count = 0;
    integer i, pos, cnt, stray;
    integer nfs = 0;
    logic mon_on = 1'b0;
    logic [31:0] rd;
    logic er;
    logic [4:0] cb;
    logic jb;

    always #50 pclk = ~pclk;

    tja_far_end u_far (.slot(slot), .cpat(cpat), .link_clock(a_clk),
        .link_data(a_data), .link_fs(a_fs), .trib_clock(t_clk),
        .trib_data(t_data), .frame_no(frame_no));

    // single source on this access point
    tja_adapter #(.AIS_CYCLES(AIS)) u_dut (.pclk(pclk), .presetn(presetn),
        .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .aggregate_adapted_data(a_data),
        .aggregate_adapted_clock(a_clk), .aggregate_frame_start(a_fs),
        .aggregate_trail_fail(trail_fail), .tributary_out_data(out_data),
        .tributary_out_clock(), .tributary_server_fail(ssf),
        .tributary_in_data(t_data), .tributary_in_clock(t_clk),
        .aggregate_timing_clock(a_clk), .aggregate_timing_frame_start(a_fs),
        .src_aggregate_data(s_data), .src_aggregate_clock(s_clk),
        .src_aggregate_frame_start(s_fs), .src_aggregate_drive_n(s_drive_n));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            n = n + 1;
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) chk(32'h0000_0000, 32'h0000_0001);
    endtask

    function logic vote(input logic [4:0] p);
        vote = (p[0] + p[1] + p[2] + p[3] + p[4]) > 2;
    endfunction

    task tally_and_finish;
        $display("mismatches %0d of %0d checks", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // source frame monitor, bit sampled mid-bit
    // ---------------------------------------------------------------
    always @(posedge s_clk) begin
        if (s_fs === 1'b1) begin
            if (mon_on && nfs > 0) begin
                chk(cnt, 728);
                chk(stray, 0);
                chk(cb, {5{cb[0]}});
                if (cb[0] === 1'b1) chk(jb, 1'b0);
            end
            nfs = nfs + 1;
            pos = 0;
            cnt = 0;
            stray = 0;
        end
        if (s_drive_n === 1'b0) begin
            cnt = cnt + 1;
            if (pos % 4 != slot || pos < 16) stray = stray + 1;
        end
        if (pos / 488 != 0 && pos % 488 < 4 && pos % 4 == slot)
            cb[pos / 488 - 1] = s_data;
        if (pos / 488 == 5 && pos % 488 == 4 + slot) jb = s_data;
        pos = pos + 1;
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk(out_data, 1'b1);
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk(rd, {28'h000_0000, `TJA_CTRL_RESET});
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b1, 8'h08, 32'hFFFF_FFFF);
        chk(er, 1'b1);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk({er, rd[30:0]}, 32'h8000_0000);
        slot = 2'($random(seed));
        apb(1'b1, 8'h00, {28'h000_0000, slot, 2'b11});
        mon_on <= 1'b1;
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk(rd, {28'h000_0000, slot, 2'b11});
        @(frame_no);
        for (i = 0; i < 2; i = i + 1) begin
            @(posedge pclk);
            cpat <= pats[i];
            @(frame_no);
            apb(1'b0, 8'h04, 32'h0000_0000);
            chk(rd[`TJA_ST_JUST], vote(pats[i]));
        end
        trail_fail <= 1'b1;
        repeat (AIS + 100) @(posedge pclk);
        chk(ssf, 1'b1);
        chk(out_data, 1'b1);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk(rd[`TJA_ST_SSF], 1'b1);
        trail_fail <= 1'b0;
        repeat (AIS + 100) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk(rd[`TJA_ST_ALARM], 1'b0);
        apb(1'b1, 8'h00, 32'h0000_0000);
        repeat (100) @(posedge pclk);
        chk(ssf, 1'b0);
        chk(out_data, 1'b1);
        chk(s_drive_n, 1'b1);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        tally_and_finish;
    end

    initial begin
        #8_000_000;
        err_count = err_count + 1;
        tally_and_finish;
    end
endmodule // testbench
